// ===== orcl_params.svh
// constants for the output relay condition logic
`ifndef ORCL_PARAMS_SVH
`define ORCL_PARAMS_SVH

// ********************************************************
// timing
// ********************************************************
`define ORCL_CLK_MHZ 50
`define ORCL_TICK_MS 10
`define ORCL_TICK_CYCLES (`ORCL_TICK_MS * 1000 * `ORCL_CLK_MHZ)
`define ORCL_RELEASE_MS 100
`define ORCL_RELEASE_TICKS (`ORCL_RELEASE_MS / `ORCL_TICK_MS)
`define ORCL_DECISEC_TICKS (100 / `ORCL_TICK_MS)
`define ORCL_CNT_W 24

// ********************************************************
// register byte offsets
// ********************************************************
`define ORCL_FUNC_SEL 12'h000
`define ORCL_AGREE_LVL 12'h004
`define ORCL_DELAYS 12'h008
`define ORCL_LOW_LVL 12'h00C
`define ORCL_BRK_FREQ 12'h010
`define ORCL_BRK_TQ 12'h014
`define ORCL_TIMER_DLY 12'h018
`define ORCL_OUT_TYPE 12'h01C
`define ORCL_DI_SEL_A 12'h020
`define ORCL_DI_SEL_B 12'h024
`define ORCL_STATUS 12'h028
`define ORCL_INT_STAT 12'h02C
`define ORCL_INT_MASK 12'h030

// ********************************************************
// writable bits and reset values
// ********************************************************
`define ORCL_FUNC_SEL_MASK 32'h3F3F_3F3F
`define ORCL_AGREE_MASK 32'h3FFF_3FFF
`define ORCL_DELAYS_MASK 32'hFFFF_007F
`define ORCL_LOW_MASK 32'h0000_3FFF
`define ORCL_BRK_FREQ_MASK 32'hFFFF_FFFF
`define ORCL_BRK_TQ_MASK 32'h00FF_FFFF
`define ORCL_TIMER_MASK 32'hFFFF_FFFF
`define ORCL_OUT_TYPE_MASK 32'h0000_0207
`define ORCL_DI_A_MASK 32'h3F3F_3F3F
`define ORCL_DI_B_MASK 32'h0000_3F3F
`define ORCL_DELAYS_RST 32'h0000_0001
`define ORCL_AGREE_RST 32'h0000_0001

// ********************************************************
// function codes
// ********************************************************
`define ORCL_CODE_AGREE 6'd13
`define ORCL_CODE_BRAKE 6'd14
`define ORCL_CODE_TIMER_OUT 6'd27
`define ORCL_CODE_TIMER_IN 6'd35
`define ORCL_CODE_LOW_CUR 6'd57

`endif

// ===== orcl_pkg.sv
// types of the output relay condition logic
`include "orcl_params.svh"

package orcl_pkg;

    typedef logic [`ORCL_CNT_W-1:0] orcl_cnt_t;

    typedef struct packed {
        logic [31:0] funcSel;
        logic [31:0] agreeLvl;
        logic [31:0] delays;
        logic [31:0] lowLvl;
        logic [31:0] brkFreq;
        logic [31:0] brkTq;
        logic [31:0] timerDly;
        logic [31:0] outType;
        logic [31:0] diSelA;
        logic [31:0] diSelB;
        logic [3:0] intStat;
        logic [3:0] intMask;
        logic [31:0] rdata;
        logic [5:0] diMeta;
        logic [5:0] diSync;
        logic [18:0] tickCnt;
        logic agreeOn;
        logic lowOn;
        logic brkFreqOn;
        logic brkOn;
        logic timerOn;
        orcl_cnt_t agreeCnt;
        orcl_cnt_t lowCnt;
        orcl_cnt_t brkCnt;
        orcl_cnt_t timerCnt;
        logic [2:0] relays;
        logic opto;
    } orcl_state_t;

endpackage : orcl_pkg

// ===== orcl_output_relay.sv
// relay and photo-coupler output condition logic with apb registers
//
// Functional notes
// - code 13 asserts on current above agree level
// - release level clamped to agree level
// - agree detection delayed by set time
// - agree drops 100 ms after current low
// - code 57 asserts on current below level
// - low-current level zero disables detection
// - low-current delay qualified, 100 ms release
// - brake on at release level accelerating
// - brake off at operation level decelerating
// - relay type bits select contact polarity
// - photo-coupler two type bit 9 at one selects B
// - timer needs input 35 and output 27
// - timer on after continuous on-delay
// - timer off after continuous off-delay
// - hold brake torque level and delay
// - brake waits delay after frequency and torque
//
// The placing of the registers and register access over APB were chosen for this implementation.
`include "orcl_params.svh"

module orcl_output_relay
    import orcl_pkg::*;
#(
    parameter int TICK_CYCLES = `ORCL_TICK_CYCLES
)(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [13:0] outCurrent,
    input wire logic [15:0] outFreq,
    input wire logic [7:0] outTorque,
    input wire logic running,
    input wire logic accelerating,
    input wire logic decelerating,
    input wire logic [5:0] digitalIn,
    output logic relay_one,
    output logic relay_two,
    output logic relay_three,
    output logic optocoupler_out_two,
    output logic irq
);

    // ********************************************************
    // helpers
    // ********************************************************
    function automatic logic [4:0] regDecode(input logic [11:0] addr);
        logic [4:0] r;
        r = 5'h00;
        unique case (addr)
            `ORCL_FUNC_SEL: r = 5'h10;
            `ORCL_AGREE_LVL: r = 5'h11;
            `ORCL_DELAYS: r = 5'h12;
            `ORCL_LOW_LVL: r = 5'h13;
            `ORCL_BRK_FREQ: r = 5'h14;
            `ORCL_BRK_TQ: r = 5'h15;
            `ORCL_TIMER_DLY: r = 5'h16;
            `ORCL_OUT_TYPE: r = 5'h17;
            `ORCL_DI_SEL_A: r = 5'h18;
            `ORCL_DI_SEL_B: r = 5'h19;
            `ORCL_STATUS: r = 5'h1A;
            `ORCL_INT_STAT: r = 5'h1B;
            `ORCL_INT_MASK: r = 5'h1C;
            default: r = 5'h00;
        endcase
        return r;
    endfunction : regDecode

    // one delayed flag: set and clear conditions each need an unbroken run
    // a full count flips on the next tick, so a free-running tick never cuts a delay short
    function automatic logic [`ORCL_CNT_W:0] stepDelay(
        input logic on,
        input orcl_cnt_t cnt,
        input logic setCond,
        input logic clrCond,
        input orcl_cnt_t setTicks,
        input orcl_cnt_t clrTicks,
        input logic tick
    );
        logic cond;
        orcl_cnt_t tgt;
        logic [`ORCL_CNT_W:0] r;
        cond = on ? clrCond : setCond;
        tgt = on ? clrTicks : setTicks;
        if (!cond)
        begin
            r = {on, {`ORCL_CNT_W{1'b0}}};
        end
        else if ((tgt == '0) || (tick && (cnt >= tgt)))
        begin
            r = {~on, {`ORCL_CNT_W{1'b0}}};
        end
        else if (tick)
        begin
            r = {on, cnt + `ORCL_CNT_W'(1)};
        end
        else
        begin
            r = {on, cnt};
        end
        return r;
    endfunction : stepDelay

    function automatic logic condSelect(
        input logic [5:0] code,
        input logic agree,
        input logic low,
        input logic brake,
        input logic timer
    );
        logic r;
        unique case (code)
            `ORCL_CODE_AGREE: r = agree;
            `ORCL_CODE_LOW_CUR: r = low;
            `ORCL_CODE_BRAKE: r = brake;
            `ORCL_CODE_TIMER_OUT: r = timer;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : condSelect

    // ********************************************************
    // state
    // ********************************************************
    orcl_state_t s_q;
    orcl_state_t s_d;

    logic [4:0] rIdx;
    logic rValid;
    logic wrEn;
    logic rdDone;
    logic tick;
    logic [13:0] level2;
    logic agreeSet;
    logic agreeClr;
    logic lowEn;
    logic lowCond;
    logic brkCond;
    logic [5:0] diTimer;
    logic timerIn;
    logic timerEn;
    logic [23:0] outCodes;
    logic [3:0] conds;
    logic [`ORCL_CNT_W:0] stepAgree;
    logic [`ORCL_CNT_W:0] stepLow;
    logic [`ORCL_CNT_W:0] stepBrk;
    logic [`ORCL_CNT_W:0] stepTimer;

    assign rIdx = regDecode(paddr);
    assign rValid = rIdx[4];
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~rValid;
    assign wrEn = psel & penable & pwrite & rValid;
    assign rdDone = psel & penable & ~pwrite & (rIdx == 5'h1B);
    assign tick = (s_q.tickCnt == 19'(TICK_CYCLES - 1));

    // ********************************************************
    // conditions
    // ********************************************************
    // the release level can never sit above the agree level
    assign level2 = (s_q.agreeLvl[29:16] > s_q.agreeLvl[13:0]) ?
        s_q.agreeLvl[13:0] : s_q.agreeLvl[29:16];
    assign agreeSet = outCurrent > s_q.agreeLvl[13:0];
    assign agreeClr = outCurrent <= level2;
    assign lowEn = s_q.lowLvl[13:0] != 14'h0000;
    assign lowCond = lowEn & (outCurrent < s_q.lowLvl[13:0]);
    assign brkCond = s_q.brkFreqOn & running &
        (outTorque > s_q.brkTq[7:0]);

    generate
        for (genvar i = 0; i < 6; i++)
        begin : g_di
            logic [5:0] code;
            if (i < 4)
            begin : g_a
                assign code = s_q.diSelA[8*i +: 6];
            end
            else
            begin : g_b
                assign code = s_q.diSelB[8*(i-4) +: 6];
            end
            assign diTimer[i] = (code == `ORCL_CODE_TIMER_IN) & s_q.diSync[i];
        end
    endgenerate

    assign timerIn = |diTimer;
    assign outCodes = {s_q.funcSel[29:24], s_q.funcSel[21:16], s_q.funcSel[13:8],
        s_q.funcSel[5:0]};
    // the timer runs only when both ends of it are assigned
    assign timerEn = ((s_q.funcSel[5:0] == `ORCL_CODE_TIMER_OUT) |
        (s_q.funcSel[13:8] == `ORCL_CODE_TIMER_OUT) |
        (s_q.funcSel[21:16] == `ORCL_CODE_TIMER_OUT) |
        (s_q.funcSel[29:24] == `ORCL_CODE_TIMER_OUT)) &
        (|{s_q.diSelA[5:0] == `ORCL_CODE_TIMER_IN, s_q.diSelA[13:8] == `ORCL_CODE_TIMER_IN,
        s_q.diSelA[21:16] == `ORCL_CODE_TIMER_IN, s_q.diSelA[29:24] == `ORCL_CODE_TIMER_IN,
        s_q.diSelB[5:0] == `ORCL_CODE_TIMER_IN, s_q.diSelB[13:8] == `ORCL_CODE_TIMER_IN});

    assign stepAgree = stepDelay(s_q.agreeOn, s_q.agreeCnt, agreeSet, agreeClr,
        `ORCL_CNT_W'(s_q.delays[6:0]) * `ORCL_CNT_W'(`ORCL_DECISEC_TICKS),
        `ORCL_CNT_W'(`ORCL_RELEASE_TICKS), tick);
    assign stepLow = stepDelay(s_q.lowOn, s_q.lowCnt, lowCond, ~lowCond,
        `ORCL_CNT_W'(s_q.delays[31:16]),
        `ORCL_CNT_W'(`ORCL_RELEASE_TICKS), tick);
    assign stepBrk = stepDelay(s_q.brkOn, s_q.brkCnt, brkCond, ~brkCond,
        `ORCL_CNT_W'(s_q.brkTq[23:8]), `ORCL_CNT_W'(0), tick);
    assign stepTimer = stepDelay(s_q.timerOn, s_q.timerCnt, timerIn, ~timerIn,
        `ORCL_CNT_W'(s_q.timerDly[15:0]) * `ORCL_CNT_W'(`ORCL_DECISEC_TICKS),
        `ORCL_CNT_W'(s_q.timerDly[31:16]) * `ORCL_CNT_W'(`ORCL_DECISEC_TICKS),
        tick);

    // ********************************************************
    // next state
    // ********************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.diMeta = digitalIn;
        s_d.diSync = s_q.diMeta;
        s_d.tickCnt = tick ? 19'h0_0000 : s_q.tickCnt + 19'h0_0001;

        {s_d.agreeOn, s_d.agreeCnt} = stepAgree;
        if (lowEn)
        begin
            {s_d.lowOn, s_d.lowCnt} = stepLow;
        end
        else
        begin
            s_d.lowOn = 1'b0;
            s_d.lowCnt = '0;
        end
        {s_d.brkOn, s_d.brkCnt} = stepBrk;
        if (timerEn)
        begin
            {s_d.timerOn, s_d.timerCnt} = stepTimer;
        end
        else
        begin
            s_d.timerOn = 1'b0;
            s_d.timerCnt = '0;
        end

        // frequency hysteresis for the brake relay
        if (!running)
        begin
            s_d.brkFreqOn = 1'b0;
        end
        else if (accelerating && outFreq >= s_q.brkFreq[15:0])
        begin
            s_d.brkFreqOn = 1'b1;
        end
        else if (decelerating && outFreq <= s_q.brkFreq[31:16])
        begin
            s_d.brkFreqOn = 1'b0;
        end

        // polarity last, on the delayed conditions
        for (int i = 0; i < 3; i++)
        begin
            s_d.relays[i] = condSelect(outCodes[6*i +: 6], s_q.agreeOn, s_q.lowOn,
                s_q.brkOn, s_q.timerOn) ^ s_q.outType[i];
        end
        s_d.opto = condSelect(outCodes[23:18], s_q.agreeOn, s_q.lowOn, s_q.brkOn,
            s_q.timerOn) ^ s_q.outType[9];

        // setup phase loads read data so it is stable in the access phase
        if (psel && !penable)
        begin
            unique case (rIdx)
                5'h10: s_d.rdata = s_q.funcSel;
                5'h11: s_d.rdata = s_q.agreeLvl;
                5'h12: s_d.rdata = s_q.delays;
                5'h13: s_d.rdata = s_q.lowLvl;
                5'h14: s_d.rdata = s_q.brkFreq;
                5'h15: s_d.rdata = s_q.brkTq;
                5'h16: s_d.rdata = s_q.timerDly;
                5'h17: s_d.rdata = s_q.outType;
                5'h18: s_d.rdata = s_q.diSelA;
                5'h19: s_d.rdata = s_q.diSelB;
                5'h1A: s_d.rdata = {10'h000, s_q.diSync, 1'b0, lowEn, timerEn,
                    s_q.brkFreqOn, conds, s_q.opto, s_q.relays, 4'h0};
                5'h1B: s_d.rdata = {28'h000_0000, s_q.intStat};
                5'h1C: s_d.rdata = {28'h000_0000, s_q.intMask};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end

        if (wrEn)
        begin
            unique case (rIdx)
                5'h10: s_d.funcSel = pwdata & `ORCL_FUNC_SEL_MASK;
                5'h11: s_d.agreeLvl = pwdata & `ORCL_AGREE_MASK;
                5'h12: s_d.delays = pwdata & `ORCL_DELAYS_MASK;
                5'h13: s_d.lowLvl = pwdata & `ORCL_LOW_MASK;
                5'h14: s_d.brkFreq = pwdata & `ORCL_BRK_FREQ_MASK;
                5'h15: s_d.brkTq = pwdata & `ORCL_BRK_TQ_MASK;
                5'h16: s_d.timerDly = pwdata & `ORCL_TIMER_MASK;
                5'h17: s_d.outType = pwdata & `ORCL_OUT_TYPE_MASK;
                5'h18: s_d.diSelA = pwdata & `ORCL_DI_A_MASK;
                5'h19: s_d.diSelB = pwdata & `ORCL_DI_B_MASK;
                5'h1C: s_d.intMask = pwdata[3:0];
                default: s_d.intMask = s_q.intMask;
            endcase
        end

        // a new event in the clearing read survives it
        s_d.intStat = (s_q.intStat & ~{4{rdDone}}) |
            ({s_d.timerOn, s_d.brkOn, s_d.lowOn, s_d.agreeOn} & ~conds);
    end

    assign conds = {s_q.timerOn, s_q.brkOn, s_q.lowOn, s_q.agreeOn};

    // ********************************************************
    // registers
    // ********************************************************
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
            s_q.agreeLvl <= `ORCL_AGREE_RST;
            s_q.delays <= `ORCL_DELAYS_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign relay_one = s_q.relays[0];
    assign relay_two = s_q.relays[1];
    assign relay_three = s_q.relays[2];
    assign optocoupler_out_two = s_q.opto;
    assign irq = |(s_q.intStat & s_q.intMask);

endmodule : orcl_output_relay

// ===== orcl_output_relay_properties.sv
// concurrent checks on the relay condition outputs
`include "orcl_params.svh"
module orcl_props
    import orcl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [13:0] outCurrent,
    input wire logic relay_one,
    input wire logic relay_two,
    input wire logic relay_three,
    input wire logic optocoupler_out_two
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // shadow of the settings
    // ********
    logic [31:0] fsel_q, otype_q, agree_q, lowLvl_q;
    logic [1:0] quiet_q;
    logic wr;
    logic ok;
    logic [13:0] relLvl;
    assign wr = psel && penable && pwrite;
    // outputs lag a write by two cycles, so judge only after a quiet spell
    assign ok = quiet_q == 2'd3;
    assign relLvl = agree_q[29:16] > agree_q[13:0] ? agree_q[13:0] : agree_q[29:16];
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            fsel_q <= 32'h0000_0000;
            otype_q <= 32'h0000_0000;
            agree_q <= `ORCL_AGREE_RST;
            lowLvl_q <= 32'h0000_0000;
            quiet_q <= 2'd0;
        end
        else
        begin
            quiet_q <= wr ? 2'd0 : (ok ? 2'd3 : quiet_q + 2'd1);
            if (wr && paddr == `ORCL_FUNC_SEL)
                fsel_q <= pwdata;
            if (wr && paddr == `ORCL_OUT_TYPE)
                otype_q <= pwdata;
            if (wr && paddr == `ORCL_AGREE_LVL)
                agree_q <= pwdata;
            if (wr && paddr == `ORCL_LOW_LVL)
                lowLvl_q <= pwdata;
        end
    end
    // ********
    // properties
    // ********
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    property p_idle_one;
        ok && fsel_q[5:0] == 6'h00 |-> relay_one == otype_q[0];
    endproperty
    property p_idle_two;
        ok && fsel_q[13:8] == 6'h00 |-> relay_two == otype_q[1];
    endproperty
    property p_idle_three;
        ok && fsel_q[21:16] == 6'h00 |-> relay_three == otype_q[2];
    endproperty
    property p_idle_opto;
        ok && fsel_q[29:24] == 6'h00 |-> optocoupler_out_two == otype_q[9];
    endproperty
    property p_low_off;
        ok && fsel_q[13:8] == `ORCL_CODE_LOW_CUR && lowLvl_q[13:0] == 14'h0000
            |-> relay_two == otype_q[1];
    endproperty
    property p_agree_rise;
        ok && fsel_q[5:0] == `ORCL_CODE_AGREE && !otype_q[0] && $rose(relay_one)
            |-> $past(outCurrent, 3) > agree_q[13:0];
    endproperty
    property p_agree_fall;
        ok && fsel_q[5:0] == `ORCL_CODE_AGREE && !otype_q[0] && $fell(relay_one)
            |-> $past(outCurrent, 3) <= relLvl;
    endproperty
    property p_low_rise;
        ok && fsel_q[13:8] == `ORCL_CODE_LOW_CUR && !otype_q[1] && $rose(relay_two)
            |-> $past(outCurrent, 3) < lowLvl_q[13:0];
    endproperty
    a_idle_one: assert property (p_idle_one) else $error("relay one polarity wrong");
    a_idle_two: assert property (p_idle_two) else $error("relay two polarity wrong");
    a_idle_three: assert property (p_idle_three) else $error("relay three polarity");
    a_idle_opto: assert property (p_idle_opto) else $error("opto output polarity");
    a_low_off: assert property (p_low_off) else $error("low detect not disabled");
    a_agree_rise: assert property (p_agree_rise) else $error("agree set too low");
    a_agree_fall: assert property (p_agree_fall) else $error("agree release level");
    a_low_rise: assert property (p_low_rise) else $error("low set above level");
    c_agree: cover property (fsel_q[5:0] == `ORCL_CODE_AGREE && $rose(relay_one));
    c_low: cover property ($rose(relay_two));
    c_brake: cover property ($rose(relay_three));
endmodule : orcl_props

bind orcl_output_relay orcl_props i_props (.ref_clk(ref_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .outCurrent(outCurrent), .relay_one(relay_one), .relay_two(relay_two),
    .relay_three(relay_three), .optocoupler_out_two(optocoupler_out_two));

// ===== orcl_contacts_model.sv
// relay contact and photo-coupler stage model with pickup lag
module orcl_contacts_model
    import orcl_pkg::*;
#(
    parameter int SETTLE = 2
)(
    input wire logic ref_clk,
    input wire logic [3:0] drive,
    output logic [3:0] closed
);
    timeunit 1ns;
    timeprecision 1ps;
    // a contact follows its coil only after SETTLE cycles, between 1 and 8
    logic [3:0] hist [0:7];
    always_ff @(posedge ref_clk)
    begin
        hist[0] <= drive;
        for (int i = 1; i < 8; i++)
            hist[i] <= hist[i-1];
    end
    assign closed = hist[SETTLE-1];
endmodule : orcl_contacts_model

// ===== orcl_output_relay_tb.sv
// self-checking bench of the relay condition logic
`include "orcl_params.svh"
module orcl_output_relay_tb
    import orcl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, irq, lastErr;
    logic [13:0] outCurrent = 14'h0000;
    logic [15:0] outFreq = 16'h0000;
    logic [7:0] outTorque = 8'h00;
    logic running = 0, accelerating = 0, decelerating = 0;
    logic [5:0] digitalIn = 6'h00;
    logic [3:0] outs, closed;
    int n_errors = 0, checked = 0;
    orcl_output_relay #(.TICK_CYCLES(10)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .outCurrent(outCurrent),
        .outFreq(outFreq), .outTorque(outTorque), .running(running),
        .accelerating(accelerating), .decelerating(decelerating), .digitalIn(digitalIn),
        .relay_one(outs[0]), .relay_two(outs[1]), .relay_three(outs[2]),
        .optocoupler_out_two(outs[3]), .irq(irq));
    orcl_contacts_model #(.SETTLE(2)) i_contacts (.ref_clk(ref_clk), .drive(outs),
        .closed(closed));
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end
    // ********
    // shared tasks
    // ********
    task automatic test_done;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge ref_clk);
            if (pready === 1'b1)
                break;
        end
        q = prdata;
        lastErr = pslverr;
        psel <= 0;
        penable <= 0;
        if (i == 20)
        begin
            n_errors++;
            test_done();
        end
    endtask : apb
    // waits up to hi cycles for the level; it must not come before lo
    task automatic settle(input int idx, input logic val, input int lo, input int hi);
        int i;
        for (i = 0; i < hi; i++)
        begin
            @(posedge ref_clk);
            #1;
            if (outs[idx] === val)
                break;
        end
        check($sformatf("output %0d timing %0d", idx, i), 32'(i >= lo && i < hi), 1);
        @(posedge ref_clk);
    endtask : settle
    task automatic hold(input int n, input int idx, input logic val);
        repeat (n) @(posedge ref_clk);
        #1;
        check($sformatf("output %0d level", idx), outs[idx], val);
        @(posedge ref_clk);
    endtask : hold
    // ********
    // scenarios
    // ********
    task automatic t_regs;
        apb(0, `ORCL_DELAYS, 32'h0000_0000);
        check("delays", q, `ORCL_DELAYS_RST);
        apb(1, `ORCL_FUNC_SEL, 32'hFFFF_FFFF);
        apb(0, `ORCL_FUNC_SEL, 32'h0000_0000);
        check("funcSel", q, `ORCL_FUNC_SEL_MASK);
        apb(0, 12'h040, 32'h0000_0000);
        check("unmapped", {q[31:1], lastErr}, 32'h0000_0001);
        apb(1, `ORCL_FUNC_SEL, 32'h0000_0000);
        $display("regs test done");
    endtask : t_regs
    task automatic t_polarity;
        for (int b = 0; b < 4; b++)
        begin
            apb(1, `ORCL_OUT_TYPE, b == 3 ? 32'h0000_0200 : 32'(1) << b);
            repeat (6) @(posedge ref_clk);
            #1;
            check("contacts", {28'h0, closed}, 32'(1) << b);
        end
        apb(1, `ORCL_OUT_TYPE, 32'h0000_0000);
        $display("polarity test done");
    endtask : t_polarity
    task automatic t_agree;
        apb(1, `ORCL_AGREE_LVL, 32'h0050_0032);
        apb(1, `ORCL_INT_MASK, 32'h0000_0001);
        apb(1, `ORCL_FUNC_SEL, 32'h0000_000D);
        outCurrent <= 14'h003C;
        repeat (50) @(posedge ref_clk);
        outCurrent <= 14'h0028;
        repeat (20) @(posedge ref_clk);
        outCurrent <= 14'h003C;
        settle(0, 1, 95, 120);
        check("irq", irq, 1);
        apb(0, `ORCL_INT_STAT, 32'h0000_0000);
        check("intStat", q[0], 1);
        outCurrent <= 14'h0037;
        #1;
        check("irqClear", irq, 0);
        hold(150, 0, 1);
        outCurrent <= 14'h0032;
        settle(0, 0, 95, 120);
        $display("agree test done");
    endtask : t_agree
    task automatic t_low;
        apb(1, `ORCL_FUNC_SEL, 32'h0000_3900);
        outCurrent <= 14'h000A;
        hold(150, 1, 0);
        apb(1, `ORCL_DELAYS, 32'h000A_0001);
        apb(1, `ORCL_LOW_LVL, 32'h0000_001E);
        settle(1, 1, 95, 120);
        check("irqMasked", irq, 0);
        apb(0, `ORCL_INT_STAT, 32'h0000_0000);
        check("intStatLow", q[1], 1);
        outCurrent <= 14'h001E;
        settle(1, 0, 95, 120);
        $display("low current test done");
    endtask : t_low
    task automatic t_brake;
        apb(1, `ORCL_FUNC_SEL, 32'h000E_0000);
        apb(1, `ORCL_BRK_FREQ, 32'h01F4_03E8);
        apb(1, `ORCL_BRK_TQ, 32'h0000_0A14);
        running <= 1;
        accelerating <= 1;
        outTorque <= 8'h32;
        outFreq <= 16'h0384;
        hold(150, 2, 0);
        outFreq <= 16'h03E8;
        settle(2, 1, 95, 120);
        accelerating <= 0;
        decelerating <= 1;
        outFreq <= 16'h02BC;
        hold(50, 2, 1);
        outFreq <= 16'h01F4;
        settle(2, 0, 0, 5);
        decelerating <= 0;
        accelerating <= 1;
        outTorque <= 8'h0A;
        outFreq <= 16'h03E8;
        hold(150, 2, 0);
        $display("brake test done");
    endtask : t_brake
    task automatic t_timer;
        apb(1, `ORCL_FUNC_SEL, 32'h1B00_0000);
        apb(1, `ORCL_TIMER_DLY, 32'h0002_0001);
        digitalIn <= 6'h01;
        hold(150, 3, 0);
        digitalIn <= 6'h00;
        apb(1, `ORCL_DI_SEL_A, 32'h0000_0023);
        repeat (5) @(posedge ref_clk);
        digitalIn <= 6'h01;
        settle(3, 1, 95, 125);
        digitalIn <= 6'h00;
        settle(3, 0, 195, 225);
        $display("timer test done");
    endtask : t_timer
    initial
    begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1;
        t_regs();
        t_polarity();
        t_agree();
        t_low();
        t_brake();
        t_timer();
        test_done();
    end
endmodule : orcl_output_relay_tb
